// ### verilog/dmcu_pkg.sv
// constants and types shared by the debug control register block
package dmcu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [31:0] DMCU_IDENT_ADDR = 32'he0042000;
    localparam logic [31:0] DMCU_CFG_ADDR   = 32'he0042004;

    ////////////////////////////////////////////////////////////////////////////
    // identity register fields
    localparam int DMCU_IDENT_LSB  = 0;
    localparam int DMCU_IDENT_W    = 12;
    localparam int DMCU_WAFER_LSB  = 16;
    localparam int DMCU_WAFER_W    = 16;

    ////////////////////////////////////////////////////////////////////////////
    // configuration register fields
    localparam int DMCU_SLEEP_BIT    = 0;
    localparam int DMCU_STOP_BIT     = 1;
    localparam int DMCU_STANDBY_BIT  = 2;
    localparam int DMCU_TRACE_EN_BIT = 5;
    localparam int DMCU_TRACE_FMT_LSB = 6;
    localparam int DMCU_IWDG_BIT     = 8;
    localparam int DMCU_WWDG_BIT     = 9;
    localparam int DMCU_TMR_LSB      = 10;
    localparam int DMCU_TMR_COUNT    = 4;
    localparam int DMCU_CAN1_BIT     = 14;
    localparam int DMCU_I2C1_BIT     = 15;
    localparam int DMCU_I2C2_BIT     = 16;
    localparam int DMCU_CAN2_BIT     = 21;

    // implemented bits; reserved 4:3, 20:17 and 31:22 stay zero
    localparam logic [31:0] DMCU_CFG_MASK  = 32'h0021ffe7;
    localparam logic [31:0] DMCU_CFG_RESET = 32'h00000000;
    localparam logic [31:0] DMCU_TRACE_FMT_MASK = 32'h000000c0;

    ////////////////////////////////////////////////////////////////////////////
    // trace format codes and sync data widths
    localparam logic [1:0] DMCU_TRACE_ASYNC = 2'h0;
    localparam logic [1:0] DMCU_TRACE_SYNC1 = 2'h1;
    localparam logic [1:0] DMCU_TRACE_SYNC2 = 2'h2;
    localparam logic [1:0] DMCU_TRACE_SYNC4 = 2'h3;
    localparam logic [2:0] DMCU_WIDTH_NONE  = 3'h0;
    localparam logic [2:0] DMCU_WIDTH_1     = 3'h1;
    localparam logic [2:0] DMCU_WIDTH_2     = 3'h2;
    localparam logic [2:0] DMCU_WIDTH_4     = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // bus answers
    localparam logic [1:0]  DMCU_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  DMCU_RESP_SLVERR = 2'h2;
    localparam logic [3:0]  DMCU_BYTES_FULL  = 4'hf;
    localparam logic [31:0] DMCU_DATA_ZERO   = 32'h00000000;

    typedef enum logic {DMCU_IDLE, DMCU_ANSWER} dmcu_bus_state_t;

endpackage

// ### verilog/dmcu_cfg_store.sv
// configuration word held on the power-on reset domain
`timescale 1ns/1ns
module dmcu_cfg_store
    import dmcu_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        porRst,
    input  wire logic        wrEn,
    input  wire logic [31:0] wrData,
    output logic      [31:0] cfgValue
);

    typedef struct packed {
        logic [31:0] cfg;
    } dmcu_store_t;

    dmcu_store_t st_reg;
    dmcu_store_t st_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        if (wrEn) begin
            // reserved bits never take a write
            st_next.cfg = wrData & DMCU_CFG_MASK;
            // format only moves while the written word keeps trace pins on
            if (!wrData[DMCU_TRACE_EN_BIT]) begin
                st_next.cfg = (st_next.cfg & ~DMCU_TRACE_FMT_MASK)
                            | (st_reg.cfg & DMCU_TRACE_FMT_MASK);
            end
        end
    end

    // only power-on reset clears it; system reset does not reach here
    always_ff @(posedge clk_sys or posedge porRst) begin
        if (porRst) begin
            st_reg.cfg <= DMCU_CFG_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cfgValue = st_reg.cfg;

endmodule

// ### verilog/dmcu_debug_regs.sv
// debug support registers: identity, debug configuration and their controls
`timescale 1ns/1ns

// Contract
// - identity word bits 11:0 return the fixed device code, read only
// - identity bits 31:16 return wafer revision; bits 15:12 read zero
// - configuration clears on power-on reset only, survives system reset
// - sleep under debug: bit 0 low core clock only, high both clocks
// - stop under debug: bit 1 low both off, high both on RC oscillator
// - standby under debug: bit 2 low both off, high both on RC oscillator
// - bit 5 turns the trace output pins on
// - format 00 async, 01/10/11 synchronous with width 1, 2, 4
// - bit 8 stops the independent watchdog while the core is halted
// - bit 9 stops the window watchdog while the core is halted
// - bits 13:10 freeze timers 1 to 4 while the core is halted
// - bit 14 freezes the first CAN controller while halted
// - bit 21 freezes the second CAN controller while halted
// - bit 15 freezes first I2C SMBus timeout while halted
// - bit 16 freezes second I2C SMBus timeout while halted
module dmcu_debug_regs
    import dmcu_pkg::*;
#(
    // arbitrary identity values, not those of any real part
    parameter logic [11:0] DEVICE_IDENT   = 12'h5a1,
    parameter logic [15:0] WAFER_REVISION = 16'h0001
)
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        porRst,
    // avalon-mm slave
    input  wire logic [31:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic      [1:0]  response,
    output logic             waitrequest,
    // power state of the core
    input  wire logic        coreHalted,
    input  wire logic        sleepMode,
    input  wire logic        stopMode,
    input  wire logic        standbyMode,
    // clock controls
    output logic             coreClockEnable,
    output logic             busClockEnable,
    output logic             clockFromRcOsc,
    // trace port controls
    output logic             tracePinsEnable,
    output logic             traceSyncMode,
    output logic      [1:0]  traceFormat,
    output logic      [2:0]  traceDataWidth,
    // peripheral freezes
    output logic             independentWatchdogFreeze,
    output logic             windowWatchdogFreeze,
    output logic      [3:0]  timerFreeze,
    output logic             canFirstFreeze,
    output logic             canSecondFreeze,
    output logic             i2cFirstTimeoutFreeze,
    output logic             i2cSecondTimeoutFreeze
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        dmcu_bus_state_t bus;
        logic [31:0]     rdData;
        logic [1:0]      resp;
        logic            coreClk;
        logic            busClk;
        logic            rcClk;
        logic            trEn;
        logic            trSync;
        logic [1:0]      trFmt;
        logic [2:0]      trWidth;
        logic            iwdgFrz;
        logic            wwdgFrz;
        logic [3:0]      tmrFrz;
        logic            can1Frz;
        logic            can2Frz;
        logic            i2c1Frz;
        logic            i2c2Frz;
    } dmcu_regs_t;

    dmcu_regs_t st_reg;
    dmcu_regs_t st_next;

    logic [31:0] cfgValue;
    logic [31:0] identWord;
    logic        request;
    logic        hitIdent;
    logic        hitCfg;
    logic        cfgWrEn;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    assign request  = read | write;
    assign hitIdent = (address == DMCU_IDENT_ADDR);
    assign hitCfg   = (address == DMCU_CFG_ADDR);

    always_comb begin
        identWord = DMCU_DATA_ZERO;
        identWord[DMCU_IDENT_LSB +: DMCU_IDENT_W] = DEVICE_IDENT;
        // bits 15:12 are left at zero
        identWord[DMCU_WAFER_LSB +: DMCU_WAFER_W] = WAFER_REVISION;
    end

    // one wait cycle, then the answer; write lands on the answer edge
    assign waitrequest = request & (st_reg.bus != DMCU_ANSWER);

    // narrow writes are dropped rather than merged into the word
    assign cfgWrEn = write & (st_reg.bus == DMCU_ANSWER) & hitCfg
                   & (byteenable == DMCU_BYTES_FULL);

    ////////////////////////////////////////////////////////////////////////////
    // configuration storage on the power-on domain

    dmcu_cfg_store u_cfg (
        .clk_sys  (clk_sys),
        .porRst   (porRst),
        .wrEn     (cfgWrEn),
        .wrData   (writedata),
        .cfgValue (cfgValue)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next = st_reg;

        case (st_reg.bus)
            DMCU_IDLE: begin
                if (request) begin
                    st_next.bus  = DMCU_ANSWER;
                    st_next.resp = DMCU_RESP_OKAY;
                    if (read) begin
                        if (hitIdent) begin
                            st_next.rdData = identWord;
                        end else if (hitCfg) begin
                            st_next.rdData = cfgValue;
                        end else begin
                            st_next.rdData = DMCU_DATA_ZERO;
                        end
                    end
                    if (!hitIdent && !hitCfg) begin
                        st_next.resp = DMCU_RESP_SLVERR;
                    end
                    if (write && hitIdent) begin
                        // identity is read only
                        st_next.resp = DMCU_RESP_SLVERR;
                    end
                end
            end
            DMCU_ANSWER: begin
                st_next.bus = DMCU_IDLE;
            end
            default: begin
                st_next.bus = DMCU_IDLE;
            end
        endcase

        // clock controls, deepest low-power state wins
        st_next.coreClk = 1'b1;
        st_next.busClk  = 1'b1;
        st_next.rcClk   = 1'b0;
        if (standbyMode) begin
            st_next.coreClk = cfgValue[DMCU_STANDBY_BIT];
            st_next.busClk  = cfgValue[DMCU_STANDBY_BIT];
            st_next.rcClk   = cfgValue[DMCU_STANDBY_BIT];
        end else if (stopMode) begin
            st_next.coreClk = cfgValue[DMCU_STOP_BIT];
            st_next.busClk  = cfgValue[DMCU_STOP_BIT];
            st_next.rcClk   = cfgValue[DMCU_STOP_BIT];
        end else if (sleepMode) begin
            // core clock keeps running so the debugger can reach the core
            st_next.coreClk = 1'b1;
            st_next.busClk  = cfgValue[DMCU_SLEEP_BIT];
        end

        // trace port
        st_next.trEn  = cfgValue[DMCU_TRACE_EN_BIT];
        st_next.trFmt = cfgValue[DMCU_TRACE_FMT_LSB +: 2];
        st_next.trSync = 1'b0;
        st_next.trWidth = DMCU_WIDTH_NONE;
        if (cfgValue[DMCU_TRACE_EN_BIT]) begin
            case (cfgValue[DMCU_TRACE_FMT_LSB +: 2])
                DMCU_TRACE_ASYNC: begin
                    st_next.trSync  = 1'b0;
                    st_next.trWidth = DMCU_WIDTH_NONE;
                end
                DMCU_TRACE_SYNC1: begin
                    st_next.trSync  = 1'b1;
                    st_next.trWidth = DMCU_WIDTH_1;
                end
                DMCU_TRACE_SYNC2: begin
                    st_next.trSync  = 1'b1;
                    st_next.trWidth = DMCU_WIDTH_2;
                end
                DMCU_TRACE_SYNC4: begin
                    st_next.trSync  = 1'b1;
                    st_next.trWidth = DMCU_WIDTH_4;
                end
                default: begin
                    st_next.trSync  = 1'b0;
                    st_next.trWidth = DMCU_WIDTH_NONE;
                end
            endcase
        end

        // halt freezes, none while the core runs
        st_next.iwdgFrz = cfgValue[DMCU_IWDG_BIT] & coreHalted;
        st_next.wwdgFrz = cfgValue[DMCU_WWDG_BIT] & coreHalted;
        st_next.tmrFrz  = cfgValue[DMCU_TMR_LSB +: DMCU_TMR_COUNT]
                        & {DMCU_TMR_COUNT{coreHalted}};
        st_next.can1Frz = cfgValue[DMCU_CAN1_BIT] & coreHalted;
        st_next.can2Frz = cfgValue[DMCU_CAN2_BIT] & coreHalted;
        st_next.i2c1Frz = cfgValue[DMCU_I2C1_BIT] & coreHalted;
        st_next.i2c2Frz = cfgValue[DMCU_I2C2_BIT] & coreHalted;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg.bus     <= DMCU_IDLE;
            st_reg.rdData  <= DMCU_DATA_ZERO;
            st_reg.resp    <= DMCU_RESP_OKAY;
            st_reg.coreClk <= 1'b1;
            st_reg.busClk  <= 1'b1;
            st_reg.rcClk   <= 1'b0;
            st_reg.trEn    <= 1'b0;
            st_reg.trSync  <= 1'b0;
            st_reg.trFmt   <= DMCU_TRACE_ASYNC;
            st_reg.trWidth <= DMCU_WIDTH_NONE;
            st_reg.iwdgFrz <= 1'b0;
            st_reg.wwdgFrz <= 1'b0;
            st_reg.tmrFrz  <= 4'h0;
            st_reg.can1Frz <= 1'b0;
            st_reg.can2Frz <= 1'b0;
            st_reg.i2c1Frz <= 1'b0;
            st_reg.i2c2Frz <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign readdata                  = st_reg.rdData;
    assign response                  = st_reg.resp;
    assign coreClockEnable           = st_reg.coreClk;
    assign busClockEnable            = st_reg.busClk;
    assign clockFromRcOsc            = st_reg.rcClk;
    assign tracePinsEnable           = st_reg.trEn;
    assign traceSyncMode             = st_reg.trSync;
    assign traceFormat               = st_reg.trFmt;
    assign traceDataWidth            = st_reg.trWidth;
    assign independentWatchdogFreeze = st_reg.iwdgFrz;
    assign windowWatchdogFreeze      = st_reg.wwdgFrz;
    assign timerFreeze               = st_reg.tmrFrz;
    assign canFirstFreeze            = st_reg.can1Frz;
    assign canSecondFreeze           = st_reg.can2Frz;
    assign i2cFirstTimeoutFreeze     = st_reg.i2c1Frz;
    assign i2cSecondTimeoutFreeze    = st_reg.i2c2Frz;

endmodule

// ### sim/dmcu_debug_regs_sva.sv
// assertions on the debug control register block ports
`timescale 1ns/1ns
module dmcu_debug_regs_sva
    import dmcu_pkg::*;
#(
    parameter logic [11:0] DEVICE_IDENT   = 12'h5a1,
    parameter logic [15:0] WAFER_REVISION = 16'h0001
)
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [31:0] address,
    input wire logic        read,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        coreHalted,
    input wire logic        sleepMode,
    input wire logic        stopMode,
    input wire logic        standbyMode,
    input wire logic        coreClockEnable,
    input wire logic        busClockEnable,
    input wire logic        clockFromRcOsc,
    input wire logic        tracePinsEnable,
    input wire logic        traceSyncMode,
    input wire logic [1:0]  traceFormat,
    input wire logic [2:0]  traceDataWidth,
    input wire logic        independentWatchdogFreeze,
    input wire logic        windowWatchdogFreeze,
    input wire logic [3:0]  timerFreeze,
    input wire logic        canFirstFreeze,
    input wire logic        canSecondFreeze,
    input wire logic        i2cFirstTimeoutFreeze,
    input wire logic        i2cSecondTimeoutFreeze
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [9:0] freezeAll;
    assign freezeAll = {canSecondFreeze, i2cSecondTimeoutFreeze, i2cFirstTimeoutFreeze,
        canFirstFreeze, timerFreeze, windowWatchdogFreeze, independentWatchdogFreeze};
    ////////////////////////////////////////////////////////////////////////////
    ident_code_a: assert property (
        read && !waitrequest && address == DMCU_IDENT_ADDR
        |-> readdata[11:0] == DEVICE_IDENT) else $error("identity code wrong");
    wafer_rev_a: assert property (
        read && !waitrequest && address == DMCU_IDENT_ADDR
        |-> readdata[31:12] == {WAFER_REVISION, 4'h0}) else $error("wafer field wrong");
    cfg_reserved_a: assert property (
        read && !waitrequest && address == DMCU_CFG_ADDR
        |-> (readdata & ~DMCU_CFG_MASK) == 32'h0) else $error("reserved bits not zero");
    trace_off_a: assert property (
        !tracePinsEnable |-> !traceSyncMode && traceDataWidth == DMCU_WIDTH_NONE)
        else $error("trace active");
    trace_width_a: assert property (
        tracePinsEnable |-> traceSyncMode == (traceFormat != 2'h0)
        && traceDataWidth == ((traceFormat == 2'h3) ? 3'h4 : {1'b0, traceFormat}))
        else $error("trace width wrong");
    // guard on reset: outputs hold reset values at the first edge after release
    sleep_clock_a: assert property (
        !$past(sys_rst) && $past(sleepMode) && !$past(stopMode) && !$past(standbyMode)
        |-> coreClockEnable && !clockFromRcOsc) else $error("sleep clocks wrong");
    stop_clock_a: assert property (
        !$past(sys_rst) && $past(stopMode) && !$past(standbyMode)
        |-> coreClockEnable == clockFromRcOsc && busClockEnable == clockFromRcOsc)
        else $error("stop clocks wrong");
    standby_clock_a: assert property (
        !$past(sys_rst) && $past(standbyMode)
        |-> coreClockEnable == clockFromRcOsc && busClockEnable == clockFromRcOsc)
        else $error("standby clocks wrong");
    freeze_halt_a: assert property (
        !$past(coreHalted) |-> freezeAll == 10'h000) else $error("freeze while running");
endmodule

bind dmcu_debug_regs dmcu_debug_regs_sva #(
    .DEVICE_IDENT   (DEVICE_IDENT),
    .WAFER_REVISION (WAFER_REVISION)
) chk (.*);

// ### sim/dmcu_probe.sv
// bus master standing in for the debug probe
`timescale 1ns/1ns
module dmcu_probe
    import dmcu_pkg::*;
(
    input  wire logic        clk_sys,
    output logic      [31:0] address,
    output logic             read,
    output logic             write,
    output logic      [3:0]  byteenable,
    output logic      [31:0] writedata,
    input  wire logic [31:0] readdata,
    input  wire logic [1:0]  response,
    input  wire logic        waitrequest
);
    initial begin
        address = 32'h0;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'h0;
        writedata = 32'h0;
    end
    // one word per request; idle lines flip so stale values are never trusted
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q, output logic [1:0] r);
        @(posedge clk_sys);
        address    <= a;
        read       <= !wr;
        write      <= wr;
        byteenable <= be;
        writedata  <= d;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        q = readdata;
        r = response;
        read      <= 1'b0;
        write     <= 1'b0;
        address   <= ~a;
        writedata <= ~d;
    endtask
endmodule

// ### sim/testbench.sv
// self-checking bench for the debug control register block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin errorCnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench
    import dmcu_pkg::*;
;
    localparam logic [11:0] IDENT = 12'h3c7;  // arbitrary value
    localparam logic [15:0] WAFER = 16'h00a5; // arbitrary value
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        porRst = 1'b1;
    logic        coreHalted = 1'b0;
    logic        sleepMode = 1'b0;
    logic        stopMode = 1'b0;
    logic        standbyMode = 1'b0;
    logic [31:0] address, writedata, readdata, q, w;
    logic [3:0]  byteenable, timerFreeze;
    logic [1:0]  response, r, traceFormat;
    logic [2:0]  traceDataWidth, e;
    logic        read, write, waitrequest, coreClockEnable, busClockEnable, clockFromRcOsc;
    logic        tracePinsEnable, traceSyncMode, independentWatchdogFreeze, windowWatchdogFreeze;
    logic        canFirstFreeze, canSecondFreeze, i2cFirstTimeoutFreeze, i2cSecondTimeoutFreeze;
    int          errorCnt = 0;
    int          checkCount = 0;
    int          cycleCnt = 0;
    int          fbit[10] = '{8, 9, 10, 11, 12, 13, 14, 15, 16, 21};
    wire  [9:0]  fz = {canSecondFreeze, i2cSecondTimeoutFreeze, i2cFirstTimeoutFreeze,
                       canFirstFreeze, timerFreeze, windowWatchdogFreeze, independentWatchdogFreeze};
    wire  [6:0]  tv = {tracePinsEnable, traceSyncMode, traceFormat, traceDataWidth};
    wire  [2:0]  ck = {coreClockEnable, busClockEnable, clockFromRcOsc};
    logic [9:0]  expFz;

    dmcu_debug_regs #(.DEVICE_IDENT(IDENT), .WAFER_REVISION(WAFER)) uut (.*);
    dmcu_probe probe (.*);

    always #5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    task automatic closeOut();
        $display("checks %0d errors %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycleCnt++;
        if (cycleCnt == 6000) begin
            errorCnt++;
            closeOut();
        end
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        probe.xfer(1'b1, a, d, be, q, r);
    endtask
    task automatic rd(input logic [31:0] a);
        probe.xfer(1'b0, a, 32'h0, DMCU_BYTES_FULL, q, r);
    endtask
    // derived outputs lag a config or input change by one edge
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic pulse(input logic p);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        porRst  <= p;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        porRst  <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        porRst  <= 1'b0;
        rd(DMCU_IDENT_ADDR);
        `CHK("identity", {WAFER, 4'h0, IDENT}, q)
        rd(DMCU_CFG_ADDR);
        `CHK("cfg reset", 32'h00000000, q)
        wr(DMCU_CFG_ADDR, 32'hffffffff);
        rd(DMCU_CFG_ADDR);
        `CHK("cfg reserved", 32'h0021ffe7, q)
        settle();
        `CHK("freeze running", 10'h000, fz)
        @(posedge clk_sys);
        coreHalted <= 1'b1;
        foreach (fbit[i]) begin
            w = 32'h1 << fbit[i];
            wr(DMCU_CFG_ADDR, w);
            settle();
            expFz = {w[21], w[16], w[15], w[14], w[13:10], w[9], w[8]};
            `CHK("freeze", expFz, fz)
        end
        for (int v = 0; v < 8; v++) begin
            wr(DMCU_CFG_ADDR, v);
            for (int m = 0; m < 3; m++) begin
                @(posedge clk_sys);
                sleepMode   <= (m == 0);
                stopMode    <= (m == 1);
                standbyMode <= (m == 2);
                settle();
                e = (m == 0) ? {1'b1, v[0], 1'b0} : {3{v[m]}};
                `CHK("clocks", e, ck)
            end
        end
        @(posedge clk_sys);
        standbyMode <= 1'b0;
        wr(DMCU_CFG_ADDR, 32'h00000020);
        for (int f = 0; f < 4; f++) begin
            wr(DMCU_CFG_ADDR, 32'h20 | (f << 6));
            settle();
            e = (f == 3) ? 3'h4 : f[2:0];
            `CHK("trace", {1'b1, f != 0, f[1:0], e}, tv)
        end
        wr(DMCU_CFG_ADDR, 32'h00000040);
        settle();
        `CHK("trace off", 7'h18, tv)
        wr(DMCU_CFG_ADDR, 32'h00214321);
        pulse(1'b0);
        rd(DMCU_CFG_ADDR);
        `CHK("cfg sys reset", 32'h00214321, q)
        pulse(1'b1);
        rd(DMCU_CFG_ADDR);
        `CHK("cfg por", 32'h00000000, q)
        wr(DMCU_CFG_ADDR, 32'h00000100, 4'h3);
        `CHK("partial resp", DMCU_RESP_OKAY, r)
        wr(DMCU_IDENT_ADDR, 32'hffffffff);
        `CHK("ident write", DMCU_RESP_SLVERR, r)
        rd(DMCU_IDENT_ADDR);
        `CHK("ident kept", {WAFER, 4'h0, IDENT}, q)
        rd(DMCU_CFG_ADDR);
        `CHK("partial write", 32'h00000000, q)
        rd(32'he0042008);
        `CHK("unmapped", {DMCU_RESP_SLVERR, 32'h0}, {r, q})
        closeOut();
    end
endmodule
